/* design/brs_rx_sync_status.sv */
`timescale 1ns/1ns

module brs_rx_sync_status
  import brs_pkg::*;
(
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  // Static selects and asynchronous status pins
  input  wire logic [1:0]                rx_mode_select,
  input  wire logic                      framing_pattern_select,
  input  wire logic                      bonding_inhibit_n,
  input  wire logic                      pll_lock_lost,
  // Decoded character from the decoder and elasticity buffer
  input  wire logic                      dec_valid,
  output logic                           dec_ready,
  input  wire logic [brs_pkg::BRS_DATA_W-1:0] dec_data,
  input  wire logic                      dec_special,
  input  wire logic                      dec_comma_match,
  input  wire logic                      dec_k285_match,
  input  wire logic                      dec_codeword_err,
  input  wire logic                      dec_disparity_err,
  input  wire logic                      ebuf_err,
  // Bonding control from the deskew logic
  input  wire logic                      deskew_window_expired,
  input  wire logic                      master_bonded,
  input  wire logic                      master_bond_failed,
  // Output register towards the host
  output logic                           out_valid,
  input  wire logic                      out_ready,
  output logic [brs_pkg::BRS_DATA_W-1:0] rx_data,
  output logic [brs_pkg::BRS_STAT_W-1:0] rx_char_status_code,
  output logic                           rx_locked
);
  import brs_pkg::*;
  // Pin synchroniser: three stages, a change counts once 2 and 3 agree
  logic [BRS_PIN_N-1:0] pin_raw;
  logic [BRS_PIN_N-1:0] s1_q;
  logic [BRS_PIN_N-1:0] s2_q;
  logic [BRS_PIN_N-1:0] s3_q;
  logic [BRS_PIN_N-1:0] pin_d;
  logic [BRS_PIN_N-1:0] pin_q;

  assign pin_raw = {rx_mode_select, framing_pattern_select,
                    bonding_inhibit_n, pll_lock_lost};
  genvar gi;
  generate
    for (gi = 0; gi < BRS_PIN_N; gi++) begin : g_sync
      always_comb begin
        pin_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : pin_q[gi];
      end
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          s1_q[gi]  <= BRS_PIN_RESET[gi];
          s2_q[gi]  <= BRS_PIN_RESET[gi];
          s3_q[gi]  <= BRS_PIN_RESET[gi];
          pin_q[gi] <= BRS_PIN_RESET[gi];
        end else begin
          s1_q[gi]  <= pin_raw[gi];
          s2_q[gi]  <= s1_q[gi];
          s3_q[gi]  <= s2_q[gi];
          pin_q[gi] <= pin_d[gi];
        end
      end
    end
  endgenerate
  logic [1:0] mode;
  logic       bonding;
  logic       type_b;
  logic       frame_k285;
  logic       inhibit_low;
  logic       pll_lost;
  assign mode        = pin_q[BRS_PIN_MODE_LO +: 2];
  assign bonding     = mode[BRS_MODE_BOND_BIT];
  assign type_b      = (mode[BRS_MODE_TYPE_BIT] == BRS_TYPE_B);
  assign frame_k285  = (pin_q[BRS_PIN_FRAME] == BRS_FRAME_K285);
  assign inhibit_low = ~pin_q[BRS_PIN_INH_N];
  assign pll_lost    = pin_q[BRS_PIN_PLL];
  // Character classification
  logic take;
  logic framing;
  logic dec_err;
  logic fatal;
  logic bond_fail_a;
  logic bond_fail_b;
  logic lock_b;
  assign take    = dec_valid & dec_ready;
  assign framing = frame_k285 ? dec_k285_match : dec_comma_match;
  assign dec_err = dec_codeword_err | dec_disparity_err;
  assign fatal   = ebuf_err | pll_lost;
  assign bond_fail_a = inhibit_low & deskew_window_expired;
  assign bond_fail_b = ((inhibit_low | master_bond_failed)
                        & deskew_window_expired) | dec_err;
  // Deskew logic raises master_bonded on the last framing char
  assign lock_b  = framing & master_bonded & ~dec_err;
  // Synchronisation machine and its counters
  brs_state_t     state_q;
  brs_state_t     state_d;
  logic [1:0]     mode_prev_q;
  logic [1:0]     mode_prev_d;
  logic [BRS_CNT_W-1:0] frame_run_q;
  logic [BRS_CNT_W-1:0] frame_run_d;
  logic [BRS_CNT_W-1:0] err_run_q;
  logic [BRS_CNT_W-1:0] err_run_d;
  logic [BRS_CNT_W-1:0] imv_q;
  logic [BRS_CNT_W-1:0] imv_d;
  logic                 loss_evt;

  always_comb begin
    state_d     = state_q;
    mode_prev_d = mode;
    frame_run_d = frame_run_q;
    err_run_d   = err_run_q;
    imv_d       = imv_q;
    loss_evt    = 1'b0;
    if (take) begin
      // Counts saturate at their limits
      if (!framing) begin
        frame_run_d = BRS_CNT_ZERO;
      end else if (frame_run_q != BRS_FRAME_RUN) begin
        frame_run_d = frame_run_q + BRS_CNT_ONE;
      end
      if (!dec_err) begin
        err_run_d = BRS_CNT_ZERO;
      end else if (err_run_q != BRS_ERR_RUN) begin
        err_run_d = err_run_q + BRS_CNT_ONE;
      end
      if (state_q != BRS_LOCKED) begin
        imv_d = BRS_CNT_ZERO;
      end else if (dec_err) begin
        if (imv_q != BRS_IMV_LIMIT) begin
          imv_d = imv_q + BRS_CNT_ONE;
        end
      end else if (imv_q != BRS_CNT_ZERO) begin
        imv_d = imv_q - BRS_CNT_ONE;
      end
      loss_evt = fatal | (err_run_d == BRS_ERR_RUN)
                 | (imv_d == BRS_IMV_LIMIT);
      case (state_q)
        BRS_UNLOCKED: begin
          if (framing && !fatal) begin
            state_d = BRS_REALIGN;
          end
        end
        BRS_REALIGN: begin
          if (!type_b) begin
            if (fatal || dec_err) begin
              state_d = BRS_UNLOCKED;
            end else if (bond_fail_a) begin
              state_d = BRS_BOND_FAILED;
            end else if (frame_run_d == BRS_FRAME_RUN) begin
              state_d = BRS_LOCKED;
            end
          end else begin
            if (fatal) begin
              state_d = BRS_UNLOCKED;
            end else if (bond_fail_b) begin
              state_d = BRS_BOND_FAILED;
            end else if (lock_b) begin
              state_d = BRS_LOCKED;
            end
          end
        end
        BRS_LOCKED: begin
          if (loss_evt) begin
            state_d = BRS_UNLOCKED;
          end
        end
        BRS_BOND_FAILED: begin
          if (fatal || (!type_b && dec_err)) begin
            state_d = BRS_UNLOCKED;
          end else if (framing) begin
            state_d = BRS_REALIGN;
          end
        end
        default: begin
          state_d = BRS_UNLOCKED;
        end
      endcase
    end
    if (!bonding || (mode != mode_prev_q)) begin
      state_d     = BRS_UNLOCKED;
      frame_run_d = BRS_CNT_ZERO;
      err_run_d   = BRS_CNT_ZERO;
      imv_d       = BRS_CNT_ZERO;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q     <= BRS_UNLOCKED;
      mode_prev_q <= BRS_PIN_RESET[BRS_PIN_MODE_LO +: 2];
      frame_run_q <= BRS_CNT_ZERO;
      err_run_q   <= BRS_CNT_ZERO;
      imv_q       <= BRS_CNT_ZERO;
    end else begin
      state_q     <= state_d;
      mode_prev_q <= mode_prev_d;
      frame_run_q <= frame_run_d;
      err_run_q   <= err_run_d;
      imv_q       <= imv_d;
    end
  end
  assign rx_locked = (state_q == BRS_LOCKED);
  // Status encoder, first match wins
  logic [BRS_STAT_W-1:0] code;
  logic [BRS_DATA_W-1:0] data;
  logic                  sync_loss;

  always_comb begin
    data = dec_data;
    sync_loss = bonding & ((state_q == BRS_UNLOCKED)
                | (state_q == BRS_BOND_FAILED)
                | ((state_q == BRS_LOCKED) & loss_evt));
    if (sync_loss || pll_lost || (type_b && ebuf_err)) begin
      code = BRS_ST_SYNC_LOSS;
    end else if (!type_b && ebuf_err) begin
      code = BRS_ST_EBUF_LOCK;
    end else if (type_b && bonding && state_q == BRS_REALIGN
                 && state_d == BRS_LOCKED) begin
      code = BRS_ST_EBUF_LOCK;
    end else if (bonding && state_q == BRS_REALIGN) begin
      code = BRS_ST_REALIGN;
    end else if (dec_codeword_err) begin
      code = BRS_ST_CODEWORD;
      data = BRS_SUB_C0_7;
    end else if (framing) begin
      code = BRS_ST_FRAMING;
    end else if (dec_disparity_err) begin
      code = BRS_ST_DISPARITY;
    end else if (dec_special) begin
      code = BRS_ST_SPECIAL;
    end else begin
      code = BRS_ST_DATA;
    end
  end

  // Two-entry buffer: head is the output register, skid absorbs a
  // stall so no word is lost while the source sees ready drop
  logic [BRS_BUF_W-1:0] head_q;
  logic [BRS_BUF_W-1:0] head_d;
  logic [BRS_BUF_W-1:0] skid_q;
  logic [BRS_BUF_W-1:0] skid_d;
  logic                 head_v_q;
  logic                 head_v_d;
  logic                 skid_v_q;
  logic                 skid_v_d;
  logic                 pop;
  assign dec_ready = ~skid_v_q;
  assign pop       = head_v_q & out_ready;

  always_comb begin
    head_d   = head_q;
    head_v_d = head_v_q;
    skid_d   = skid_q;
    skid_v_d = skid_v_q;
    if (pop || !head_v_q) begin
      if (skid_v_q) begin
        head_d   = skid_q;
        head_v_d = 1'b1;
        skid_v_d = 1'b0;
      end else if (take) begin
        head_d   = {code, data};
        head_v_d = 1'b1;
      end else begin
        head_v_d = 1'b0;
      end
    end else if (take) begin
      skid_d   = {code, data};
      skid_v_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      head_q   <= '0;
      head_v_q <= 1'b0;
      skid_q   <= '0;
      skid_v_q <= 1'b0;
    end else begin
      head_q   <= head_d;
      head_v_q <= head_v_d;
      skid_q   <= skid_d;
      skid_v_q <= skid_v_d;
    end
  end

  assign out_valid           = head_v_q;
  assign rx_data             = head_q[BRS_DATA_W-1:0];
  assign rx_char_status_code = head_q[BRS_BUF_W-1:BRS_DATA_W];

endmodule : brs_rx_sync_status

/* design/brs_pkg.sv */
package brs_pkg;

  // Widths
  localparam int unsigned BRS_DATA_W = 8;
  localparam int unsigned BRS_STAT_W = 3;
  localparam int unsigned BRS_CNT_W  = 3;
  localparam int unsigned BRS_BUF_W  = BRS_DATA_W + BRS_STAT_W;
  localparam int unsigned BRS_PIN_N  = 5;

  // Status codes, listed with their priority (1 is highest)
  localparam logic [2:0] BRS_ST_DATA      = 3'h0; // priority 8
  localparam logic [2:0] BRS_ST_SPECIAL   = 3'h1; // priority 7
  localparam logic [2:0] BRS_ST_EBUF_LOCK = 3'h2; // priority 2
  localparam logic [2:0] BRS_ST_FRAMING   = 3'h3; // priority 5
  localparam logic [2:0] BRS_ST_CODEWORD  = 3'h4; // priority 4
  localparam logic [2:0] BRS_ST_SYNC_LOSS = 3'h5; // priority 1
  localparam logic [2:0] BRS_ST_DISPARITY = 3'h6; // priority 6
  localparam logic [2:0] BRS_ST_REALIGN   = 3'h7; // priority 3

  // Substitute character for an undecodable symbol (C0.7)
  localparam logic [7:0] BRS_SUB_C0_7 = 8'he0;

  // Run and count limits
  localparam logic [2:0] BRS_FRAME_RUN = 3'h4;
  localparam logic [2:0] BRS_ERR_RUN   = 3'h4;
  localparam logic [2:0] BRS_IMV_LIMIT = 3'h4;
  localparam logic [2:0] BRS_CNT_ZERO  = 3'h0;
  localparam logic [2:0] BRS_CNT_ONE   = 3'h1;

  // Mode select fields and encodings
  localparam int unsigned BRS_MODE_BOND_BIT = 1;
  localparam int unsigned BRS_MODE_TYPE_BIT = 0;
  localparam logic        BRS_TYPE_B        = 1'b1;
  localparam logic        BRS_FRAME_K285    = 1'b1;

  // Synchronised pin vector: [4:3] mode, [2] frame select,
  // [1] bonding inhibit (active low), [0] PLL lock lost
  localparam int unsigned BRS_PIN_MODE_LO = 3;
  localparam int unsigned BRS_PIN_FRAME   = 2;
  localparam int unsigned BRS_PIN_INH_N   = 1;
  localparam int unsigned BRS_PIN_PLL     = 0;
  localparam logic [4:0]  BRS_PIN_RESET   = 5'h03;

  typedef enum logic [3:0] {
    BRS_UNLOCKED    = 4'h1,
    BRS_REALIGN     = 4'h2,
    BRS_LOCKED      = 4'h4,
    BRS_BOND_FAILED = 4'h8
  } brs_state_t;

endpackage : brs_pkg

/* test/brs_rx_sync_status_props.sv */
`timescale 1ns/1ns
module brs_props
  import brs_pkg::*;
(
  // Clock and reset
  input wire logic                      core_clk,
  input wire logic                      rst,
  // Decoder side
  input wire logic                      dec_valid,
  input wire logic                      dec_ready,
  // Host side
  input wire logic                      out_valid,
  input wire logic                      out_ready,
  input wire logic [brs_pkg::BRS_DATA_W-1:0] rx_data,
  input wire logic [brs_pkg::BRS_STAT_W-1:0] rx_char_status_code
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_fill;
    dec_valid && dec_ready && out_valid && !out_ready;
  endsequence
  sequence s_drain;
    !dec_ready && out_ready;
  endsequence
  a_fill_refuse: assert property (s_fill |=> !dec_ready)
    else $error("ready stayed high with both entries full");
  a_drain_ready: assert property (
    s_drain |=> dec_ready && out_valid)
    else $error("skid entry not moved to head after pop");
  a_take_appears: assert property (
    dec_valid && dec_ready && !out_valid |=> out_valid)
    else $error("taken word missing one cycle later");
  a_pop_empties: assert property (
    out_valid && out_ready && dec_ready && !dec_valid |=> !out_valid)
    else $error("buffer not empty after last pop");
  a_empty_ready: assert property (!out_valid |-> dec_ready)
    else $error("ready low with empty buffer");
  a_hold_valid: assert property (
    out_valid && !out_ready |=> out_valid)
    else $error("word dropped during stall");
  a_data_stable: assert property (out_valid && !out_ready |=>
    $stable(rx_data) && $stable(rx_char_status_code))
    else $error("word changed during stall");
  a_codeword_sub: assert property (out_valid &&
    rx_char_status_code == BRS_ST_CODEWORD |-> rx_data == BRS_SUB_C0_7)
    else $error("codeword violation without substitute");
endmodule : brs_props

/* test/brs_host_model.sv */
`timescale 1ns/1ns
module brs_host_model (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Control and handshake
  input  wire logic stall,
  output logic      out_ready
);
  logic [1:0] rnd_q;
  logic       ready_d;
  // Random slow acceptance exercises the skid entry; the draw is
  // registered so it changes every cycle, not only when stall moves
  always_comb begin
    ready_d = !stall && (rnd_q != 2'h0);
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rnd_q     <= 2'h0;
      out_ready <= 1'b0;
    end else begin
      rnd_q     <= 2'($urandom);
      out_ready <= ready_d;
    end
  end
endmodule : brs_host_model

/* test/brs_rx_sync_status_bench.sv */
`timescale 1ns/1ns
module brs_rx_sync_status_bench;
  import brs_pkg::*;
  logic       core_clk = 1'b0, rst = 1'b1, stall = 1'b0;
  logic [1:0] rx_mode_select = 2'h0;
  logic       framing_pattern_select = 1'b0, bonding_inhibit_n = 1'b1;
  logic       pll_lock_lost = 1'b0, dec_valid = 1'b0, dec_special = 1'b0;
  logic [7:0] dec_data = 8'h00, rx_data;
  logic       dec_comma_match = 1'b0, dec_k285_match = 1'b0;
  logic       dec_codeword_err = 1'b0, dec_disparity_err = 1'b0;
  logic       ebuf_err = 1'b0, deskew_window_expired = 1'b0;
  logic       master_bonded = 1'b0, master_bond_failed = 1'b0;
  logic       dec_ready, out_valid, out_ready, rx_locked;
  logic [2:0] rx_char_status_code;
  int         n_mismatch = 0, num_checks = 0, e, m, k;
  int         exp_q[$];
  logic [10:0] got;
  always #4 core_clk = ~core_clk;
  brs_rx_sync_status dut_u (.core_clk(core_clk), .rst(rst),
    .rx_mode_select(rx_mode_select),
    .framing_pattern_select(framing_pattern_select),
    .bonding_inhibit_n(bonding_inhibit_n), .pll_lock_lost(pll_lock_lost),
    .dec_valid(dec_valid), .dec_ready(dec_ready), .dec_data(dec_data),
    .dec_special(dec_special), .dec_comma_match(dec_comma_match),
    .dec_k285_match(dec_k285_match), .dec_codeword_err(dec_codeword_err),
    .dec_disparity_err(dec_disparity_err), .ebuf_err(ebuf_err),
    .deskew_window_expired(deskew_window_expired),
    .master_bonded(master_bonded), .master_bond_failed(master_bond_failed),
    .out_valid(out_valid), .out_ready(out_ready), .rx_data(rx_data),
    .rx_char_status_code(rx_char_status_code), .rx_locked(rx_locked));
  brs_host_model host_u (.core_clk(core_clk), .rst(rst), .stall(stall),
    .out_ready(out_ready));
  task check(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  // Flags f: ebuf, disparity, codeword, k285, comma, special
  function int code_of(bit tb, bit pll, bit fps, logic [5:0] f,
                       logic [7:0] d);
    int c;
    if (pll) c = 5;
    else if (f[5]) c = tb ? 5 : 2;
    else if (f[3]) c = 4;
    else if (fps ? f[2] : f[1]) c = 3;
    else if (f[4]) c = 6;
    else if (f[0]) c = 1;
    else c = 0;
    // Substitute only when the codeword code itself is reported
    return (int'(c == 4 ? BRS_SUB_C0_7 : d) << 3) | c;
  endfunction : code_of
  task idle(input int n);
    dec_valid <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask : idle
  task send(input logic [7:0] d, input logic [5:0] f, input int ex);
    int  i;
    logic ok;
    dec_valid <= 1'b1;
    dec_data  <= d;
    {ebuf_err, dec_disparity_err, dec_codeword_err, dec_k285_match,
     dec_comma_match, dec_special} <= f;
    exp_q.push_back(ex);
    for (i = 0; i < 50; i++) begin
      #1 ok = dec_ready;
      @(posedge core_clk);
      if (ok === 1'b1) break;
    end
    if (i == 50) begin
      check(0, "decoder side never taken");
      stop_test;
    end
  endtask : send
  task drain;
    int i;
    idle(1);
    for (i = 0; i < 500 && exp_q.size() != 0; i++) @(posedge core_clk);
    if (exp_q.size() != 0) begin
      check(0, "words not delivered");
      stop_test;
    end
  endtask : drain
  task set_pins(input logic [1:0] md, input logic fps, input logic pll);
    drain;
    rx_mode_select <= md;
    framing_pattern_select <= fps;
    pll_lock_lost <= pll;
    idle(10);
  endtask : set_pins
  always @(posedge core_clk) begin
    if (!rst && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() == 0) check(0, "unexpected word");
      else begin
        e   = exp_q.pop_front();
        got = {rx_data, rx_char_status_code};
        check(got === e[10:0], "status or data differ");
      end
    end
  end
  initial begin
    logic [7:0] d;
    logic [5:0] f;
    int         x;
    void'($urandom(93));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    idle(6);
    for (m = 0; m < 4; m++) begin
      set_pins({1'b0, m[0]}, 1'($urandom_range(1)), m[1]);
      check(rx_locked === 1'b0, "locked while independent");
      repeat (40) begin
        d = 8'($urandom);
        f = 6'($urandom & $urandom);
        x = code_of(m[0], m[1], framing_pattern_select, f, d);
        send(d, f, x);
      end
    end
    // Lost-lock pin must be clear before plain codes are expected
    set_pins(2'h0, 1'b0, 1'b0);
    stall <= 1'b1;
    idle(3);
    send(8'h5a, 6'h00, 8'h5a << 3);
    send(8'ha5, 6'h01, (8'ha5 << 3) | 1);
    #1 check(dec_ready === 1'b0, "ready high with buffer full");
    @(posedge core_clk);
    stall <= 1'b0;
    for (m = 2; m < 4; m++) begin
      set_pins(m[1:0], 1'b1, 1'b0);
      master_bonded <= m[0];
      for (k = 0; k < 8; k++) begin
        // Type-A locks on the fourth framing char, Type-B on master lock
        if (k == 0) x = 5;
        else if (m[0]) x = (k == 1) ? 2 : 3;
        else x = (k < 4) ? 7 : 3;
        send(8'hbc, 6'h04, (8'hbc << 3) | x);
      end
      for (k = 0; k < 4; k++) send(8'(k), 6'h00, k << 3);
      drain;
      check(rx_locked === 1'b1, "not locked after framing run");
      send(8'h11, 6'h20, (8'h11 << 3) | 5);
      send(8'h22, 6'h00, (8'h22 << 3) | 5);
      drain;
      check(rx_locked === 1'b0, "still locked after buffer error");
      send(8'hbc, 6'h04, (8'hbc << 3) | 5);
      bonding_inhibit_n <= 1'b0;
      deskew_window_expired <= 1'b1;
      idle(6);
      send(8'hbc, 6'h04, (8'hbc << 3) | 7);
      send(8'h33, 6'h00, (8'h33 << 3) | 5);
      drain;
      check(rx_locked === 1'b0, "locked in bond failed state");
      bonding_inhibit_n <= 1'b1;
      deskew_window_expired <= 1'b0;
    end
    stop_test;
  end
endmodule : brs_rx_sync_status_bench
bind brs_rx_sync_status brs_props props_u (.core_clk(core_clk), .rst(rst),
  .dec_valid(dec_valid), .dec_ready(dec_ready), .out_valid(out_valid),
  .out_ready(out_ready), .rx_data(rx_data),
  .rx_char_status_code(rx_char_status_code));
